// *** tmrf_assertions.sv ***
// Purpose: port-level checks for the timer family top
// Assumes: single clock ref_clk, nrst synchronous active low
// Notes:   bound into tmrf_top below the module
`timescale 1ns/1ns
module tmrf_checker (
    input logic          ref_clk,     // bus clock
    input logic          nrst,        // reset, active low
    input logic          dbgHalt,     // debug halt
    input logic [7:0]    tmrEnable,   // timer enables
    input logic [7:0]    tmrDbgStop,  // debug freeze
    input logic [255:0]  tmrReload,   // reload values
    input logic [63:0]   chMode,      // channel modes
    input logic [1023:0] chCompare,   // compare values
    input logic [31:0]   chOut,       // channel outputs
    input logic [255:0]  tmrCount,    // counters
    input logic [7:0]    tmrUpdate,   // update pulses
    input logic [7:0]    tmrDmaReq,   // dma requests
    input logic          stEnable,    // tick enable
    input logic          stClkDiv8,   // tick divider
    input logic          stIntEnable, // tick mask
    input logic [23:0]   stReload,    // tick reload
    input logic [23:0]   stCount,     // tick count
    input logic          stFlag,      // zero flag
    input logic          stIrq        // tick request
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire stTick1 = stEnable && !stClkDiv8;
    // freeze is left out: it forces the outputs low whatever the duty
    wire pwmOn   = tmrEnable[0] && chMode[1:0] == 2'h2 && !(dbgHalt && tmrDbgStop[0]);
    sequence s_div8_step;
        stEnable && stClkDiv8 && $changed(stCount);
    endsequence
    sequence s_hold_seven;
        $stable(stCount) [*7];
    endsequence
    a_st_decrement: assert property (stTick1 && stCount != 24'h0 |=> stCount == $past(stCount) - 24'h1)
        else $error("tick count did not step down by one");
    a_st_reload: assert property (stTick1 && stCount == 24'h0 |=> stCount == $past(stReload))
        else $error("tick count not reloaded at zero");
    a_st_flag_set: assert property (stTick1 && stCount == 24'h1 |=> stFlag)
        else $error("zero flag not set");
    a_st_div_eight: assert property (s_div8_step |=> s_hold_seven)
        else $error("divided tick came early");
    a_st_irq_mask: assert property (stIrq == (stFlag && stIntEnable))
        else $error("tick request does not follow flag and mask");
    a_dma_update: assert property (tmrDmaReq == {3'h0, tmrUpdate[4:0]})
        else $error("dma request does not follow update");
    a_wrap_zero: assert property (tmrUpdate[5] |-> tmrCount[191:160] == 32'h0)
        else $error("update without wrap to zero");
    a_narrow_width: assert property ({tmrCount[255:240], tmrCount[223:208], tmrCount[191:176],
        tmrCount[127:112], tmrCount[31:16]} == 80'h0) else $error("narrow counter beyond 16 bits");
    a_pwm_low: assert property ((pwmOn && chCompare[15:0] == 16'h0) [*2] |-> !chOut[0])
        else $error("zero duty output not low");
    a_pwm_high: assert property ((pwmOn && chCompare[15:0] > tmrReload[15:0]) [*2] |-> chOut[0])
        else $error("full duty output not high");
    a_dbg_freeze: assert property (dbgHalt && tmrDbgStop[0] |=>
        tmrCount[31:0] == $past(tmrCount[31:0]) && chOut[3:0] == 4'h0) else $error("debug freeze not kept");
endmodule

bind tmrf_top tmrf_checker i_chk (
    .ref_clk, .nrst, .dbgHalt, .tmrEnable, .tmrDbgStop, .tmrReload, .chMode, .chCompare, .chOut,
    .tmrCount, .tmrUpdate, .tmrDmaReq, .stEnable, .stClkDiv8, .stIntEnable, .stReload, .stCount, .stFlag, .stIrq
);

// *** tmrf_defines.vh ***
// Functional notes
// - Every timer divides its counter clock by any whole ratio from 1 to 65536 (prescale field plus one).
// - The advanced timer has four channels, each usable for capture, compare, edge or centre PWM, or one-cycle output.
// - In PWM mode a compare of zero gives an always-low output and one above the reload gives an always-high output.
// - In debug halt the advanced timer can freeze its counter and force its channel outputs low.
// - Every timer can take another timer's update as a link trigger to reset, start or clock its own counter.
// - The two wide timers use a 32-bit up/down auto-reload counter behind a 16-bit prescaler.
// - The two narrow full timers use a 16-bit up/down auto-reload counter, 16-bit prescaler and four channels.
// - Each full-featured general timer raises its own DMA request on its update event.
// - The full-featured general timers decode quadrature encoder inputs and capture on any change of up to three hall inputs.
// - The full-featured general timers can stop their counters while debug halt is asserted.
// - The dual-channel timer counts up only on 16 bits with a 16-bit prescaler, two channels and no DMA request.
// - Each single-channel timer counts up only on 16 bits, has one channel and accepts link triggers.
// - The system tick timer is a 24-bit down counter.
// - When the system tick counter reaches zero it reloads on the next tick and raises a maskable interrupt flag.
// - The system tick counter is clocked by the bus clock or the bus clock divided by eight.
//
// Purpose: constants shared by the timer family
// Assumes: one clock, synchronous reset
// Notes:   definitions only
`ifndef TMRF_DEFINES_VH
`define TMRF_DEFINES_VH

`define TMRF_NUM_TIMERS    8
`define TMRF_MASK16        32'h0000FFFF
`define TMRF_MASK32        32'hFFFFFFFF
// counting modes
`define TMRF_CNT_UP        2'h0
`define TMRF_CNT_DOWN      2'h1
`define TMRF_CNT_CENTRE    2'h2
`define TMRF_CNT_ENCODER   2'h3
// link (slave) modes
`define TMRF_LINK_NONE     2'h0
`define TMRF_LINK_RESET    2'h1
`define TMRF_LINK_START    2'h2
`define TMRF_LINK_CLOCK    2'h3
// channel modes
`define TMRF_CH_CAPTURE    2'h0
`define TMRF_CH_COMPARE    2'h1
`define TMRF_CH_PWM        2'h2
`define TMRF_CH_PWM_INV    2'h3
// reset values
`define TMRF_RST_COUNT     32'h00000000
`define TMRF_RST_PRESCALE  16'h0000
// system tick
`define TMRF_ST_WIDTH      24
`define TMRF_ST_DIV8_LAST  3'h7
`define TMRF_ST_RST_COUNT  24'h000000

`endif

// *** tmrf_encoder_model.sv ***
// Purpose: quadrature encoder in front of a general timer
// Assumes: requests raised by the bench at falling edges
// Notes:   one count per request; gap sets how slow the phases move
`timescale 1ns/1ns
module tmrf_encoder_model (
    input  wire       ref_clk,  // bus clock
    input  wire       stepReq,  // request one count
    input  wire       stepDown, // count down
    input  wire [3:0] gap,      // cycles between phase moves
    output reg  [1:0] quad = 2'h0, // phase pins 1:0
    output reg        busy = 1'b0  // step in progress
);
    // the lagging phase moves only after the timer filter has settled on the leading one
    always @(posedge ref_clk) begin
        if (stepReq && !busy) begin
            busy <= 1'b1;
            quad <= stepDown ? {~quad[1], quad[0]} : {quad[1], ~quad[0]};
            repeat (gap) @(posedge ref_clk);
            quad <= stepDown ? {quad[1], quad[1]} : {quad[0], quad[0]};
            repeat (gap) @(posedge ref_clk);
            busy <= 1'b0;
        end
    end
endmodule

// *** tmrf_tb.sv ***
// Purpose: self-checking bench for the timer family top
// Assumes: 100 ns clock, inputs moved at falling edges
// Notes:   table rows cover plain counting, hand tests the rest
`timescale 1ns/1ns
module testbench;
    typedef struct {
        int          g;
        logic [15:0] psc;
        logic [31:0] rld;
        logic [1:0]  mode;
        int          n;
        logic [31:0] exp;
        logic        dn;
    } tmrf_row_t;
    // timer, prescale, reload, mode, edges, expected count, expected direction
    tmrf_row_t rows [8] = '{
        '{0, 16'h0000, 32'h00000002, 2'h0, 7,     32'h00000001, 1'b0},
        '{1, 16'h0001, 32'h00010005, 2'h1, 6,     32'h00010003, 1'b1},
        '{3, 16'h0002, 32'h00000004, 2'h2, 27,    32'h00000001, 1'b0},
        '{2, 16'h0000, 32'h00000003, 2'h2, 5,     32'h00000001, 1'b1},
        '{5, 16'h0000, 32'h00000003, 2'h1, 5,     32'h00000001, 1'b0},
        '{7, 16'h0000, 32'h00010003, 2'h0, 6,     32'h00000002, 1'b0},
        '{4, 16'h0003, 32'h00000009, 2'h0, 20,    32'h00000005, 1'b0},
        '{6, 16'hFFFF, 32'h00000005, 2'h0, 65536, 32'h00000001, 1'b0}
    };
    logic          ref_clk, nrst, dbgHalt, stEnable, stClkDiv8, stIntEnable, stFlagClear, stFlag, stIrq;
    logic [7:0]    tmrEnable, tmrOneCycle, tmrDbgStop, tmrHallMode, tmrUpdate, tmrDmaReq, tmrDirDown;
    logic [15:0]   tmrCountMode, tmrLinkMode;
    logic [23:0]   tmrTrigSel, stReload, stCount;
    logic [127:0]  tmrPrescale;
    logic [255:0]  tmrReload, tmrCount;
    logic [63:0]   chMode;
    logic [1023:0] chCompare, chCapture;
    logic [31:0]   chPins, chOut, hi, snap, snap3;
    logic          encReq, encDown, encBusy;
    logic [3:0]    encGap;
    logic [1:0]    encQuad;
    int            mismatches, comparisons;
    wire  [31:0]   chIn = {chPins[31:14], encQuad, chPins[11:0]};

    tmrf_top i_dut (.ref_clk, .nrst, .dbgHalt, .tmrEnable, .tmrOneCycle, .tmrDbgStop, .tmrCountMode,
        .tmrLinkMode, .tmrTrigSel, .tmrHallMode, .tmrPrescale, .tmrReload, .chMode, .chCompare, .chIn, .chOut,
        .chCapture, .tmrCount, .tmrUpdate, .tmrDmaReq, .tmrDirDown, .stEnable, .stClkDiv8, .stIntEnable,
        .stReload, .stFlagClear, .stCount, .stFlag, .stIrq);
    tmrf_encoder_model i_enc (.ref_clk, .stepReq(encReq), .stepDown(encDown), .gap(encGap), .quad(encQuad),
        .busy(encBusy));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // four held edges also flush the pin synchronisers
    task automatic reset_all(input int n);
        nrst = 1'b0;
        {dbgHalt, tmrEnable, tmrOneCycle, tmrDbgStop, tmrHallMode, stEnable, stClkDiv8, stIntEnable} = '0;
        {tmrCountMode, tmrLinkMode, tmrTrigSel, tmrPrescale, tmrReload, chMode, chCompare, chPins} = '0;
        {stReload, stFlagClear, encReq, encDown} = '0;
        encGap = 4'h5;
        repeat (n) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
    endtask
    task automatic enc_step(input logic down, input logic [3:0] gap);
        encDown = down;
        encGap = gap;
        encReq = 1'b1;
        @(negedge ref_clk);
        encReq = 1'b0;
        while (encBusy) @(negedge ref_clk);
        repeat (6) @(negedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // the longest row needs 65536 cycles, all tests well under 80000
    initial begin
        #(100000 * 100);
        mismatches++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        mismatches = 0;
        comparisons = 0;
        reset_all(16);
        foreach (rows[i]) begin
            reset_all(4);
            tmrPrescale[rows[i].g*16 +: 16] = rows[i].psc;
            tmrReload[rows[i].g*32 +: 32] = rows[i].rld;
            tmrCountMode[rows[i].g*2 +: 2] = rows[i].mode;
            tmrEnable[rows[i].g] = 1'b1;
            repeat (rows[i].n) @(negedge ref_clk);
            chk(tmrCount[rows[i].g*32 +: 32], rows[i].exp, "count");
            chk(tmrDirDown[rows[i].g], rows[i].dn, "direction");
            $display("row %0d done", i);
        end
        // timer 6 counts the updates of timer 4; timer 5 stops after one
        reset_all(4);
        tmrReload[191:128] = {32'h2, 32'h2};
        tmrReload[223:192] = 32'h9;
        tmrOneCycle[5] = 1'b1;
        tmrLinkMode[13:12] = 2'h3;
        tmrTrigSel[20:18] = 3'h4;
        tmrEnable = 8'h70;
        repeat (3) @(negedge ref_clk);
        chk(tmrUpdate[5:4], 32'h3, "update");
        chk(tmrDmaReq[5:4], 32'h1, "dma");
        repeat (9) @(negedge ref_clk);
        tmrEnable[4] = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(tmrCount[223:192], 32'h4, "linked count");
        chk(tmrCount[191:160], 32'h0, "one-cycle stop");
        $display("link test done");
        // duty 2 of 4, then full, then debug freeze
        reset_all(4);
        tmrReload[31:0] = 32'h3;
        tmrReload[127:96] = 32'h9;
        chMode[25:0] = 26'h1000002;
        chCompare[31:0] = 32'h2;
        chCompare[415:384] = 32'h5;
        tmrEnable = 8'h09;
        repeat (3) @(negedge ref_clk);
        hi = 32'h0;
        repeat (8) begin
            @(negedge ref_clk);
            hi = hi + chOut[0];
        end
        chk(hi, 32'h4, "pwm high cycles");
        chk(chOut[12], 32'h1, "compare toggle");
        chCompare[31:0] = 32'h0;
        repeat (3) @(negedge ref_clk);
        chCompare[31:0] = 32'h4;
        repeat (3) @(negedge ref_clk);
        chk(chOut[0], 32'h1, "full duty");
        dbgHalt = 1'b1;
        tmrDbgStop = 8'h09;
        repeat (2) @(negedge ref_clk);
        snap = tmrCount[31:0];
        snap3 = tmrCount[127:96];
        repeat (5) @(negedge ref_clk);
        chk(tmrCount[31:0], snap, "frozen advanced");
        chk(tmrCount[127:96], snap3, "frozen narrow");
        chk(chOut[0], 32'h0, "output off in debug");
        dbgHalt = 1'b0;
        repeat (3) @(negedge ref_clk);
        $display("pwm test done");
        // slow count keeps the value still while the pin edge is filtered
        reset_all(4);
        tmrPrescale[79:0] = {16'h0063, 48'h0, 16'h0063};
        tmrReload[159:0] = {32'h9, 96'h0, 32'h9};
        tmrHallMode = 8'h10;
        tmrEnable = 8'h11;
        repeat (150) @(negedge ref_clk);
        chPins[18:1] = 18'h20001;
        repeat (8) @(negedge ref_clk);
        chk(chCapture[63:32], 32'h1, "capture");
        chk(chCapture[543:512], 32'h1, "hall capture");
        $display("capture test done");
        reset_all(4);
        tmrCountMode[7:6] = 2'h3;
        tmrReload[127:96] = 32'h9;
        tmrEnable = 8'h08;
        for (int k = 0; k < 4; k++) enc_step(k == 3, (k == 1) ? 4'hC : 4'h5);
        chk(tmrCount[127:96], 32'h2, "encoder count");
        for (int k = 0; k < 3; k++) enc_step(1'b1, 4'h5);
        chk(tmrCount[127:96], 32'h9, "encoder wrap");
        $display("encoder test done");
        reset_all(4);
        stReload = 24'h2;
        stIntEnable = 1'b1;
        stEnable = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(stCount, 32'h0, "tick count");
        chk({stFlag, stIrq}, 32'h3, "tick flag");
        stIntEnable = 1'b0;
        stFlagClear = 1'b1;
        @(negedge ref_clk);
        chk({stCount, stFlag, stIrq}, 32'h8, "tick reload");
        reset_all(4);
        stReload = 24'h3;
        stClkDiv8 = 1'b1;
        stEnable = 1'b1;
        repeat (40) @(negedge ref_clk);
        chk(stCount, 32'h3, "divided tick");
        $display("system tick test done");
        end_of_test();
    end
endmodule

// *** tmrf_top.v ***
// Purpose: timer family: advanced, wide, narrow, dual, single-channel timers and system tick
// Assumes: ref_clk bus clock at 10 MHz, nrst synchronous active low
// Notes:   timer index 0 advanced, 1/2 wide a/b, 3/4 narrow a/b, 5 dual, 6/7 single a/b
`timescale 1ns/1ns
`include "tmrf_defines.vh"

// ----------------------------------------------------------------
// one timer of the family, shaped by parameters
// ----------------------------------------------------------------
module tmrf_timer #(
    parameter [31:0] MASK = `TMRF_MASK16,
    parameter        NCH  = 4,
    parameter        UPDN = 1,
    parameter        DMA  = 1,
    parameter        FULL = 0,
    parameter        ADV  = 0
) (
    input  wire         ref_clk,      // bus clock
    input  wire         nrst,         // synchronous reset, active low
    input  wire         enable,       // counter enable
    input  wire         oneCycle,     // stop after next update; in centre mode only at the bottom update, never in encoder mode
    input  wire         dbgStop,      // freeze while debug halt, only when FULL or ADV
    input  wire         dbgHalt,      // processor halted in debug
    input  wire [1:0]   countMode,    // up, down, centre, encoder
    input  wire [1:0]   linkMode,     // reaction to link trigger
    input  wire         trigIn,       // link trigger pulse
    input  wire         hallMode,     // channel 0 captures on hall change, only when FULL
    input  wire [15:0]  prescale,     // ratio minus one
    input  wire [31:0]  reload,       // auto-reload value
    input  wire [7:0]   chMode,       // two bits per channel
    input  wire [127:0] compare,      // 32 bits per channel
    input  wire [3:0]   chIn,         // channel pins, asynchronous
    output reg  [3:0]   chOut,        // channel outputs
    output reg  [127:0] capture,      // captured counts
    output reg  [31:0]  count,        // counter value
    output reg          update,       // one-cycle update pulse
    output wire         dmaReq,       // one-cycle dma request
    output reg          dirDown       // counting down
);
    reg  [3:0]  sync1_reg;
    reg  [3:0]  sync2_reg;
    reg  [3:0]  sync3_reg;
    reg  [3:0]  filt_reg;
    reg  [15:0] psc_reg;
    reg         runLatch_reg;
    reg         stopped_reg;
    integer     i;

    // a pin change counts only once the second and third stages agree
    wire [3:0]  filt_next = (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
    wire [31:0] top      = reload & MASK;
    wire        freeze   = dbgHalt & dbgStop & ((FULL | ADV) != 0);
    wire [1:0]  mode     = (UPDN != 0) ? countMode : `TMRF_CNT_UP;
    wire        encoder  = (FULL != 0) && (mode == `TMRF_CNT_ENCODER);
    wire        run      = enable & ~freeze & ~stopped_reg
                           & ((linkMode != `TMRF_LINK_START) | runLatch_reg);
    wire        pscTick  = (psc_reg == prescale);
    wire        aEdge    = filt_next[0] ^ filt_reg[0];
    wire        tick     = encoder ? aEdge :
                           (linkMode == `TMRF_LINK_CLOCK) ? trigIn : pscTick;
    wire        hallEdge = |(filt_next[2:0] ^ filt_reg[2:0]);

    assign dmaReq = (DMA != 0) & update;

    // ----------------------------------------------------------------
    // prescaler and counter
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!nrst) begin
            sync1_reg    <= 4'h0;
            sync2_reg    <= 4'h0;
            sync3_reg    <= 4'h0;
            filt_reg     <= 4'h0;
            psc_reg      <= `TMRF_RST_PRESCALE;
            count        <= `TMRF_RST_COUNT;
            update       <= 1'b0;
            dirDown      <= 1'b0;
            runLatch_reg <= 1'b0;
            stopped_reg  <= 1'b0;
        end else begin
            sync1_reg <= chIn;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
            update    <= 1'b0;
            if (!enable) begin
                stopped_reg  <= 1'b0;
                runLatch_reg <= 1'b0;
            end else if (trigIn && linkMode == `TMRF_LINK_START) begin
                runLatch_reg <= 1'b1;
            end
            if (trigIn && linkMode == `TMRF_LINK_RESET && enable) begin
                count   <= `TMRF_RST_COUNT;
                psc_reg <= `TMRF_RST_PRESCALE;
                dirDown <= 1'b0;
            end else if (run) begin
                psc_reg <= pscTick ? `TMRF_RST_PRESCALE : psc_reg + 16'h0001;
                if (tick) begin
                    case (mode)
                        `TMRF_CNT_UP: begin
                            dirDown <= 1'b0;
                            if (count >= top) begin
                                count  <= `TMRF_RST_COUNT;
                                update <= 1'b1;
                            end else begin
                                count <= (count + 32'h1) & MASK;
                            end
                        end
                        `TMRF_CNT_DOWN: begin
                            dirDown <= 1'b1;
                            if (count == 32'h0 || count > top) begin
                                count  <= top;
                                update <= 1'b1;
                            end else begin
                                count <= count - 32'h1;
                            end
                        end
                        `TMRF_CNT_CENTRE: begin
                            if (top == 32'h0) begin
                                count  <= `TMRF_RST_COUNT;
                                update <= 1'b1;
                            end else if (!dirDown) begin
                                if (count >= top) begin
                                    dirDown <= 1'b1;
                                    count   <= top - 32'h1;
                                    update  <= 1'b1;
                                end else begin
                                    count <= count + 32'h1;
                                end
                            end else begin
                                if (count == 32'h0) begin
                                    dirDown <= 1'b0;
                                    count   <= 32'h1;
                                    update  <= 1'b1;
                                end else begin
                                    count <= count - 32'h1;
                                end
                            end
                        end
                        default: begin
                            // quadrature: direction from phase of b against new a
                            if (filt_next[0] != filt_next[1]) begin
                                dirDown <= 1'b0;
                                count   <= (count >= top) ? `TMRF_RST_COUNT : ((count + 32'h1) & MASK);
                            end else begin
                                dirDown <= 1'b1;
                                count   <= (count == 32'h0) ? top : count - 32'h1;
                            end
                        end
                    endcase
                    if (oneCycle && mode != `TMRF_CNT_ENCODER &&
                        ((mode == `TMRF_CNT_UP && count >= top) ||
                         (mode == `TMRF_CNT_DOWN && (count == 32'h0 || count > top)) ||
                         (mode == `TMRF_CNT_CENTRE && dirDown && count == 32'h0))) begin
                        stopped_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!nrst) begin
            chOut   <= 4'h0;
            capture <= 128'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (i >= NCH || (ADV != 0 && freeze)) begin
                    chOut[i] <= 1'b0;
                end else begin
                    case (chMode[i*2 +: 2])
                        `TMRF_CH_CAPTURE: begin
                            chOut[i] <= 1'b0;
                            if ((FULL != 0 && hallMode && i == 0) ? hallEdge : (filt_next[i] && !filt_reg[i])) begin
                                capture[i*32 +: 32] <= count;
                            end
                        end
                        `TMRF_CH_COMPARE: begin
                            if (run && tick && count == (compare[i*32 +: 32] & MASK)) begin
                                chOut[i] <= ~chOut[i];
                            end
                        end
                        `TMRF_CH_PWM: chOut[i] <= (count < (compare[i*32 +: 32] & MASK));
                        default:      chOut[i] <= (count >= (compare[i*32 +: 32] & MASK));
                    endcase
                end
            end
        end
    end
endmodule

// ----------------------------------------------------------------
// family top with system tick
// ----------------------------------------------------------------
module tmrf_top (
    input  wire          ref_clk,       // bus clock
    input  wire          nrst,          // synchronous reset, active low
    input  wire          dbgHalt,       // processor halted in debug
    input  wire [7:0]    tmrEnable,     // per timer enable
    input  wire [7:0]    tmrOneCycle,   // per timer one-cycle mode
    input  wire [7:0]    tmrDbgStop,    // per timer freeze in debug, timers 0 to 4 only
    input  wire [15:0]   tmrCountMode,  // two bits per timer
    input  wire [15:0]   tmrLinkMode,   // two bits per timer
    input  wire [23:0]   tmrTrigSel,    // three bits: source timer
    input  wire [7:0]    tmrHallMode,   // per timer hall capture, timers 1 to 4 only
    input  wire [127:0]  tmrPrescale,   // 16 bits per timer
    input  wire [255:0]  tmrReload,     // 32 bits per timer
    input  wire [63:0]   chMode,        // 8 bits per timer
    input  wire [1023:0] chCompare,     // 128 bits per timer
    input  wire [31:0]   chIn,          // 4 pins per timer
    output wire [31:0]   chOut,         // 4 outputs per timer
    output wire [1023:0] chCapture,     // 128 bits per timer
    output wire [255:0]  tmrCount,      // 32 bits per timer
    output wire [7:0]    tmrUpdate,     // update pulses
    output wire [7:0]    tmrDmaReq,     // dma request pulses
    output wire [7:0]    tmrDirDown,    // counting down
    input  wire          stEnable,      // system tick enable
    input  wire          stClkDiv8,     // tick on bus clock / 8
    input  wire          stIntEnable,   // interrupt mask
    input  wire [23:0]   stReload,      // reload value
    input  wire          stFlagClear,   // clear zero flag
    output reg  [23:0]   stCount,       // current value
    output reg           stFlag,        // reached-zero flag
    output wire          stIrq          // masked interrupt request
);
    reg  [2:0] stDiv_reg;
    genvar     g;

    generate
        for (g = 0; g < `TMRF_NUM_TIMERS; g = g + 1) begin : gTimer
            tmrf_timer #(
                .MASK ((g == 1 || g == 2) ? `TMRF_MASK32 : `TMRF_MASK16),
                .NCH  (g <= 4 ? 4 : (g == 5 ? 2 : 1)),
                .UPDN (g <= 4 ? 1 : 0),
                .DMA  (g <= 4 ? 1 : 0),
                .FULL ((g >= 1 && g <= 4) ? 1 : 0),
                .ADV  (g == 0 ? 1 : 0)
            ) uTimer (
                .ref_clk   (ref_clk),
                .nrst      (nrst),
                .enable    (tmrEnable[g]),
                .oneCycle  (tmrOneCycle[g]),
                .dbgStop   (tmrDbgStop[g]),
                .dbgHalt   (dbgHalt),
                .countMode (tmrCountMode[g*2 +: 2]),
                .linkMode  (tmrLinkMode[g*2 +: 2]),
                .trigIn    (tmrUpdate[tmrTrigSel[g*3 +: 3]]),
                .hallMode  (tmrHallMode[g]),
                .prescale  (tmrPrescale[g*16 +: 16]),
                .reload    (tmrReload[g*32 +: 32]),
                .chMode    (chMode[g*8 +: 8]),
                .compare   (chCompare[g*128 +: 128]),
                .chIn      (chIn[g*4 +: 4]),
                .chOut     (chOut[g*4 +: 4]),
                .capture   (chCapture[g*128 +: 128]),
                .count     (tmrCount[g*32 +: 32]),
                .update    (tmrUpdate[g]),
                .dmaReq    (tmrDmaReq[g]),
                .dirDown   (tmrDirDown[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // system tick
    // ----------------------------------------------------------------
    wire stTick = ~stClkDiv8 | (stDiv_reg == `TMRF_ST_DIV8_LAST);
    wire stHit  = stEnable & stTick & (stCount == 24'h000001);

    assign stIrq = stFlag & stIntEnable;

    always @(posedge ref_clk) begin
        if (!nrst) begin
            stDiv_reg <= 3'h0;
            stCount   <= `TMRF_ST_RST_COUNT;
            stFlag    <= 1'b0;
        end else begin
            stDiv_reg <= stDiv_reg + 3'h1;
            if (stEnable && stTick) stCount <= (stCount == 24'h000000) ? stReload : stCount - 24'h000001;
            // a new zero wins over a clear in the same cycle
            if (stHit) begin
                stFlag <= 1'b1;
            end else if (stFlagClear) begin
                stFlag <= 1'b0;
            end
        end
    end
endmodule
